// file: ccr_map.svh
// Offsets, field positions, field masks and timing counts of the card config registers
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// Register port word addresses (32-bit words)
`define CCR_ADDR_W            6
`define CCR_A_OVR             6'h00
`define CCR_A_CID0            6'h04
`define CCR_A_CSD0            6'h08
`define CCR_A_RCA             6'h0C
`define CCR_A_CTRL            6'h0D
`define CCR_A_CSDW            6'h0E
`define CCR_A_SHIFT           6'h0F

// Operating voltage register
`define CCR_OVR_WIN_LO        4
`define CCR_OVR_WIN_HI        23
`define CCR_OVR_ADV_LO        15
`define CCR_OVR_ADV_HI        23
`define CCR_OVR_BUSY_BIT      31

// Identity register fields
`define CCR_CID_MAKER_HI      127
`define CCR_CID_MAKER_LO      120
`define CCR_CID_OEM_HI        119
`define CCR_CID_OEM_LO        104
`define CCR_CID_NAME_HI       103
`define CCR_CID_NAME_LO       64
`define CCR_CID_REV_HI        63
`define CCR_CID_REV_LO        56
`define CCR_CID_SN_HI         55
`define CCR_CID_SN_LO         24
`define CCR_CID_RSV_HI        23
`define CCR_CID_RSV_LO        20
`define CCR_CID_DATE_HI       19
`define CCR_CID_DATE_LO       8
`define CCR_CRC_HI            7
`define CCR_CRC_LO            1
`define CCR_MSG_LO            8

// Card specific data fields
`define CCR_CSD_VER_HI        127
`define CCR_CSD_VER_LO        126
`define CCR_CSD_RBL_HI        83
`define CCR_CSD_RBL_LO        80
`define CCR_CSD_PART_BIT      79
`define CCR_CSD_RBL_2G        4'hA
`define CCR_CSD_RBL_1G        4'h9
`define CCR_CSD_OTP_HI        15
`define CCR_CSD_OTP_LO        13
`define CCR_CSD_OTP_MASK      16'hE000
`define CCR_CSD_TMP_BIT       12
`define CCR_CSD_FMT_HI        11
`define CCR_CSD_FMT_LO        8
`define CCR_CSD_FMT_MASK      16'h0F00
`define CCR_CSD_TMP_MASK      16'h1000
`define CCR_CSD_RO_MASK       16'h00FF

// CRC7 generator x^7 + x^3 + 1
`define CCR_CRC7_POLY         7'h09

// Power-up delay, 1 ms at 40 MHz
`define CCR_PWRUP_NS          1000000
`define CCR_CLK_NS            25
`define CCR_PWRUP_CYC         ((`CCR_PWRUP_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)

`endif

// file: ccr_pkg.sv
// Types of the card config registers
package ccr_pkg;
    typedef enum logic [1:0] {CCR_SH_IDLE, CCR_SH_RUN} ccr_shift_e;
    typedef logic [127:0] ccr_wide_t;
endpackage

// file: ccr_regs.sv
// Card configuration register set: voltage, identity and specific data
`timescale 1ns/100ps
`include "ccr_map.svh"
// Summary of operation
// - 32-bit voltage register, windows bits 4-23
// - Bit 31 flags power-up finished
// - Advertise only 2.7 to 3.6 V windows
// - Identity register fixed, host writes ignored
// - Identity fields at documented bit slices
// - Revision is two BCD nibbles, major upper
// - CRC7 over bits 127:8, x^7+x^3+1
// - Identity bit 0 always one
// - Data fields obey read-only, OTP, erasable
// - Block length A for 2G, else 9
// - Partial read flag reads one
// - Relative address held for session
module ccr_regs
#(
    parameter int          PWRUP_CYCLES = `CCR_PWRUP_CYC,
    parameter logic [7:0]  MAKER_CODE   = 8'h5A,
    parameter logic [15:0] OEM_CODE     = 16'h5858,
    parameter logic [39:0] PRODUCT_NAME = 40'h4341524431,
    parameter logic [7:0]  PRODUCT_REV  = 8'h10,
    parameter logic [31:0] SERIAL_NUM   = 32'h00000001,
    parameter logic [11:0] MAKE_DATE    = 12'h000,
    parameter bit          CAP_2G       = 1'b1
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic [`CCR_ADDR_W-1:0] addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr_stb,
    input  wire logic                   rd_stb,
    output logic [31:0]                 rdata,
    output logic                        power_up_done,
    output logic                        shift_bit,
    output logic                        shift_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Constant images
    // Maker and OEM codes are arbitrary defaults, set per product.
    localparam logic [119:0] CID_MSG = {MAKER_CODE, OEM_CODE, PRODUCT_NAME,
        PRODUCT_REV, SERIAL_NUM, 4'h0, MAKE_DATE};

    function automatic logic [6:0] crc7(input logic [119:0] msg);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--)
        begin
            fb = msg[i] ^ c[6];
            c  = {c[5:0], 1'b0} ^ (fb ? `CCR_CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    localparam ccr_pkg::ccr_wide_t CID_IMG = {CID_MSG, crc7(CID_MSG), 1'b1};

    localparam logic [31:0] OVR_WIN = 32'h00FF8000;

    // Read-only part of the data register image
    localparam logic [3:0] RBL = CAP_2G ? `CCR_CSD_RBL_2G : `CCR_CSD_RBL_1G;
    localparam logic [111:0] CSD_RO_HI = {2'b00, 6'h00, 8'h26, 8'h00, 8'h32,
        12'h5F5, RBL, 1'b1, 3'b000, 2'b00, 12'hF24, 3'b111, 3'b110,
        3'b111, 3'b110, 3'b111, 1'b1, 7'h1F, 7'h7F, 1'b1, 2'b00,
        3'b100, RBL, 1'b0, 5'h00};
    localparam logic [15:0] CSD_LO_RST = 16'h4000;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up sequence
    logic [$clog2(PWRUP_CYCLES+1)-1:0] pwr_cnt_reg;
    logic                              pwr_done_reg;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pwr_cnt_reg  <= '0;
            pwr_done_reg <= 1'b0;
        end
        else if (!pwr_done_reg)
        begin
            pwr_cnt_reg <= pwr_cnt_reg + 1'b1;
            if (pwr_cnt_reg == ($bits(pwr_cnt_reg))'(PWRUP_CYCLES - 1))
                pwr_done_reg <= 1'b1;
        end
    end
    assign power_up_done = pwr_done_reg;

    wire logic [31:0] ovr_val = OVR_WIN | {pwr_done_reg, 31'h0};

    ////////////////////////////////////////////////////////////////////////////
    // Writable low part of the data register and relative address
    logic [15:0] csd_lo_reg;
    logic [2:0]  otp_used_reg;
    logic [15:0] rca_reg;
    wire  logic [15:0] csd_lo_next;
    wire  logic        csd_wr = wr_stb && addr == `CCR_A_CSDW;

    // One-time cells: OTP bits write once, format bits lock on that same first write
    assign csd_lo_next =
        (csd_lo_reg & `CCR_CSD_RO_MASK)
        | (otp_used_reg[0] ? csd_lo_reg & `CCR_CSD_OTP_MASK : wdata[15:0] & `CCR_CSD_OTP_MASK)
        | (otp_used_reg[1] ? csd_lo_reg & `CCR_CSD_FMT_MASK : wdata[15:0] & `CCR_CSD_FMT_MASK)
        | (wdata[15:0] & `CCR_CSD_TMP_MASK);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            csd_lo_reg   <= CSD_LO_RST;
            otp_used_reg <= 3'b000;
        end
        else if (csd_wr)
        begin
            csd_lo_reg   <= csd_lo_next;
            otp_used_reg <= 3'b011;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rca_reg <= 16'h0000;
        else if (wr_stb && addr == `CCR_A_RCA)
            rca_reg <= wdata[15:0];
    end

    // Low byte of the data register is recomputed so its CRC stays valid
    wire logic [119:0] csd_msg = {CSD_RO_HI, csd_lo_reg[15:8]};
    wire ccr_pkg::ccr_wide_t csd_img = {csd_msg, crc7(csd_msg), 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Serial return of a 128-bit register
    ccr_pkg::ccr_shift_e sh_state_reg;
    ccr_pkg::ccr_wide_t  sh_data_reg;
    logic [6:0]          sh_cnt_reg;
    logic                sh_bit_reg;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sh_state_reg <= ccr_pkg::CCR_SH_IDLE;
            sh_data_reg  <= '0;
            sh_cnt_reg   <= 7'h00;
            sh_bit_reg   <= 1'b1;
        end
        else
        begin
            case (sh_state_reg)
                ccr_pkg::CCR_SH_IDLE:
                begin
                    sh_bit_reg <= 1'b1;
                    if (wr_stb && addr == `CCR_A_SHIFT)
                    begin
                        sh_data_reg  <= wdata[0] ? csd_img : CID_IMG;
                        sh_cnt_reg   <= 7'h00;
                        sh_state_reg <= ccr_pkg::CCR_SH_RUN;
                    end
                end
                ccr_pkg::CCR_SH_RUN:
                begin
                    sh_bit_reg  <= sh_data_reg[127];
                    sh_data_reg <= {sh_data_reg[126:0], 1'b0};
                    sh_cnt_reg  <= sh_cnt_reg + 7'h01;
                    if (sh_cnt_reg == 7'h7F)
                        sh_state_reg <= ccr_pkg::CCR_SH_IDLE;
                end
                default:
                    sh_state_reg <= ccr_pkg::CCR_SH_IDLE;
            endcase
        end
    end
    assign shift_bit = sh_bit_reg;

    logic busy_reg;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            busy_reg <= 1'b0;
        else
            busy_reg <= (sh_state_reg == ccr_pkg::CCR_SH_RUN) && sh_cnt_reg != 7'h7F
                        || (sh_state_reg == ccr_pkg::CCR_SH_IDLE && wr_stb
                            && addr == `CCR_A_SHIFT);
    end
    assign shift_busy = busy_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read port; identity writes have no decode and fall away
    logic [31:0] rd_reg;
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h00000000;
        case (addr)
            `CCR_A_OVR:      rd_mux = ovr_val;
            6'h04:           rd_mux = CID_IMG[127:96];
            6'h05:           rd_mux = CID_IMG[95:64];
            6'h06:           rd_mux = CID_IMG[63:32];
            6'h07:           rd_mux = CID_IMG[31:0];
            6'h08:           rd_mux = csd_img[127:96];
            6'h09:           rd_mux = csd_img[95:64];
            6'h0A:           rd_mux = csd_img[63:32];
            6'h0B:           rd_mux = csd_img[31:0];
            `CCR_A_RCA:      rd_mux = {16'h0000, rca_reg};
            `CCR_A_CTRL:     rd_mux = {29'h0, otp_used_reg[0], busy_reg, pwr_done_reg};
            default:         rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rd_reg <= 32'h00000000;
        else if (rd_stb)
            rd_reg <= rd_mux;
        else
            rd_reg <= 32'h00000000;
    end
    assign rdata = rd_reg;

endmodule

// file: ccr_regs_asserts.sv
// Port checks of the card config registers
`timescale 1ns/100ps
`include "ccr_map.svh"
module ccr_regs_asserts
#(
    parameter int PWRUP_CYCLES = 8,
    parameter bit CAP_2G       = 1'b1
)
(
    input wire logic                   sys_clk,
    input wire logic                   rst,
    input wire logic [`CCR_ADDR_W-1:0] addr,
    input wire logic [31:0]            wdata,
    input wire logic                   wr_stb,
    input wire logic                   rd_stb,
    input wire logic [31:0]            rdata,
    input wire logic                   power_up_done,
    input wire logic                   shift_bit,
    input wire logic                   shift_busy
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
int unsigned pcnt;
////////////////////////////////
// Counts cycles spent waiting for power-up
always_ff @(posedge sys_clk or posedge rst)
    if (rst)
        pcnt <= 0;
    else if (!power_up_done)
        pcnt <= pcnt + 1;
sequence rd_of(logic [5:0] a);
    $past(rd_stb) && $past(addr) == a;
endsequence
////////////////////////////////
AST_RD_IDLE: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("rdata not zero outside read slot");
AST_OVR_WIN: assert property (rd_of(6'h00) |-> rdata[30:0] == 31'h00FF8000)
    else $error("voltage windows wrong");
AST_OVR_DONE: assert property ($past(rd_stb) && $past(addr) == 6'h00 && $past(power_up_done)
    |-> rdata[31])
    else $error("voltage bit 31 low after power-up");
AST_PWR_KEEP: assert property (power_up_done |=> power_up_done)
    else $error("power-up flag dropped");
AST_PWR_LATE: assert property (pcnt <= PWRUP_CYCLES + 2)
    else $error("power-up too late");
AST_PWR_EARLY: assert property (power_up_done |-> pcnt >= PWRUP_CYCLES - 1)
    else $error("power-up too early");
AST_SH_GO: assert property ($past(wr_stb) && $past(addr) == 6'h0F && !$past(shift_busy)
    |-> shift_busy)
    else $error("shift did not start");
AST_SH_LEN: assert property ($rose(shift_busy) |-> ##127 shift_busy ##1 !shift_busy)
    else $error("shift length wrong");
AST_SH_IDLE: assert property (!shift_busy && !$past(shift_busy) |-> shift_bit)
    else $error("serial line not idle high");
AST_SH_LAST: assert property ($fell(shift_busy) |-> shift_bit)
    else $error("last serial bit not one");
AST_CSD_RBL: assert property (rd_of(6'h09) |-> rdata[19:15] == {(CAP_2G ? 4'hA : 4'h9), 1'b1})
    else $error("block length or partial flag wrong");
AST_CSD_VER: assert property (rd_of(6'h08) |-> rdata[31:30] == 2'b00)
    else $error("layout version wrong");
AST_CID_LSB: assert property (rd_of(6'h07) |-> rdata[0])
    else $error("identity bit 0 not one");
cover property ($rose(shift_busy));
cover property (rd_of(6'h09));
cover property (wr_stb && addr == 6'h0E);
endmodule

bind ccr_regs ccr_regs_asserts #(.PWRUP_CYCLES(PWRUP_CYCLES), .CAP_2G(CAP_2G)) u_chk
    (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
     .rd_stb(rd_stb), .rdata(rdata), .power_up_done(power_up_done),
     .shift_bit(shift_bit), .shift_busy(shift_busy));

// file: ccr_host.sv
// Host side capture of 128-bit serial register transfers
`timescale 1ns/100ps
module ccr_host
(
    input  wire logic          sys_clk,
    input  wire logic          shift_bit,
    input  wire logic          shift_busy,
    output ccr_pkg::ccr_wide_t cap
);
logic busy_d;
////////////////////////////////
// Bits trail busy by one cycle, so sample on the delayed flag
always_ff @(posedge sys_clk)
begin
    if (busy_d)
        cap <= {cap[126:0], shift_bit};
    busy_d <= shift_busy;
end
endmodule

// file: ccr_regs_bench.sv
// Self-checking bench of the card config registers
`timescale 1ns/100ps
module ccr_regs_bench;
logic               sys_clk, rst, wr_stb, rd_stb, power_up_done, shift_bit, shift_busy;
logic [5:0]         addr;
logic [31:0]        wdata, rdata, v, r;
ccr_pkg::ccr_wide_t cap, card_identity, card_specific_data;
int                 fails, n_checks, cyc;
logic [31:0]        seed = 32'h7F248066;
// Maker code 8'h7E is arbitrary
ccr_regs #(.PWRUP_CYCLES(8), .MAKER_CODE(8'h7E)) dut (.sys_clk(sys_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .power_up_done(power_up_done), .shift_bit(shift_bit), .shift_busy(shift_busy));
ccr_host host (.sys_clk(sys_clk), .shift_bit(shift_bit), .shift_busy(shift_busy), .cap(cap));
////////////////////////////////
initial sys_clk = 1'b0;
always #12.5 sys_clk = ~sys_clk;
always @(posedge sys_clk)
begin
    cyc++;
    if (cyc == 3000)
    begin
        fails++;
        finish_test();
    end
end
////////////////////////////////
function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
function automatic logic [6:0] crc7(input logic [119:0] m);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 119; i >= 0; i--)
        c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
endfunction
task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
    n_checks++;
    if (s !== e)
    begin
        fails++;
        $display("unexpected %s expected %h seen %h", n, e, s);
    end
endtask
task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
endtask
task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
endtask
// Bounded wait, plus one edge so the host holds the last bit
task automatic shift_wait();
    repeat (200)
    begin
        @(posedge sys_clk);
        #1;
        if (shift_busy === 1'b0)
            break;
    end
    @(posedge sys_clk);
    #1;
endtask
task automatic finish_test();
    if (fails == 0 && n_checks > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
////////////////////////////////
initial
begin
    rst = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    card_identity = {8'h7E, 16'h5858, 40'h4341524431, 8'h10, 32'h1, 4'h0, 12'h000, 8'h00};
    card_identity[7:0] = {crc7(card_identity[127:8]), 1'b1};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(6'h00);
    chk("voltage", v, 32'h00FF8000);
    repeat (12) @(posedge sys_clk);
    rd(6'h00);
    chk("voltage", v, 32'h80FF8000);
    for (int i = 4; i < 12; i++)
        wr(i[5:0], xs());
    for (int i = 0; i < 4; i++)
    begin
        rd(6'h04 + i[5:0]);
        chk("identity", v, card_identity[127 - 32 * i -: 32]);
        rd(6'h08 + i[5:0]);
        card_specific_data[127 - 32 * i -: 32] = v;
    end
    chk("block length", card_specific_data[83:79], 5'b10101);
    wr(6'h0E, 32'h5000);
    rd(6'h0B);
    chk("protect", v[15:8], 8'h50);
    wr(6'h0E, 32'hE800);
    rd(6'h0B);
    chk("protect", v[15:8], 8'h40);
    card_specific_data[31:0] = v;
    chk("data crc", card_specific_data[7:0], {crc7(card_specific_data[127:8]), 1'b1});
    rd(6'h0D);
    chk("status", v, 32'h5);
    r = xs();
    wr(6'h0C, r);
    rd(6'h0C);
    chk("address", v[15:0], r[15:0]);
    rd(6'h20);
    chk("unmapped", v, 32'h0);
    wr(6'h0F, 32'h0);
    wr(6'h0F, 32'h1);
    shift_wait();
    chk("identity serial", cap, card_identity);
    wr(6'h0F, 32'h1);
    shift_wait();
    chk("data serial", cap, card_specific_data);
    finish_test();
end
endmodule
